/* File: verilog/efsc_pkg.sv */
package efsc_pkg;

	// ----------------------------------------------------------------
	// Bus and counter geometry
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int CNT_W = 16;
	localparam int CNT_MSB = 15;
	localparam int NUM_CNT = 5;

	// ----------------------------------------------------------------
	// Register map: base word plus set, clear and invert aliases
	// ----------------------------------------------------------------
	localparam logic [7:0] TX_OK_OFS = 8'h00;
	localparam logic [7:0] ONE_COL_OFS = 8'h10;
	localparam logic [7:0] MANY_COL_OFS = 8'h20;
	localparam logic [7:0] RX_OK_OFS = 8'h30;
	localparam logic [7:0] CSUM_ERR_OFS = 8'h40;
	localparam logic [1:0] ALIAS_BASE = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// Counter indices
	localparam int IDX_TX_OK = 0;
	localparam int IDX_ONE_COL = 1;
	localparam int IDX_MANY_COL = 2;
	localparam int IDX_RX_OK = 3;
	localparam int IDX_CSUM_ERR = 4;

	typedef struct packed {
		logic frame_ok;
		logic one_collision;
		logic many_collision;
	} efsc_tx_evt_t;

	typedef struct packed {
		logic frame_done;
		logic filter_accept;
		logic checksum_error;
		logic dribble;
	} efsc_rx_evt_t;

endpackage

/* File: verilog/efsc_counters.sv */
`timescale 1ns/1ps
// Overview of operation
// - A 16-bit counter counts every frame sent successfully.
// - A 16-bit counter counts frames sent after exactly one collision.
// - A 16-bit counter counts frames sent after more than one collision.
// - A 16-bit counter counts frames accepted by the receive filter.
// - Frames with checksum or alignment error never count as received ok.
// - The three transmit counters react only to transmit strobes.
// - The two receive counters react only to receive strobes.
// - A read clears the counter unless byte lanes 0 and 1 are both off.
// - Bits 31 to 16 read zero and ignore writes.
// - The checksum error counter counts bad frames of whole octets.
module efsc_counters
	import efsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [efsc_pkg::APB_AW-1:0] paddr,
	input wire logic [efsc_pkg::APB_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [efsc_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire efsc_pkg::efsc_tx_evt_t tx_evt,
	input wire efsc_pkg::efsc_rx_evt_t rx_evt
);
	import efsc_pkg::*;

	// ----------------------------------------------------------------
	// Local types and sizes
	// ----------------------------------------------------------------
	// Read data carries the count in the low half, zeros above
	localparam int PAD_W = APB_DW - CNT_W;
	localparam logic [2:0] SEL_TX_OK = 3'(IDX_TX_OK);
	localparam logic [2:0] SEL_ONE_COL = 3'(IDX_ONE_COL);
	localparam logic [2:0] SEL_MANY_COL = 3'(IDX_MANY_COL);
	localparam logic [2:0] SEL_RX_OK = 3'(IDX_RX_OK);
	localparam logic [2:0] SEL_CSUM_ERR = 3'(IDX_CSUM_ERR);

	// Setup is tracked so a stray enable without setup is never taken
	typedef enum
	{
		PH_IDLE,
		PH_SETUP,
		PH_ANSWER
	} efsc_phase_t;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	efsc_phase_t phase_reg;
	efsc_phase_t phase_next;
	logic access;

	logic aligned;
	logic hit;
	logic [2:0] sel_idx;
	logic [1:0] alias_kind;

	logic rd_lanes;
	logic [CNT_W-1:0] lane_mask;
	logic [CNT_W-1:0] wr_mask;
	logic [NUM_CNT-1:0] mine;
	logic [NUM_CNT-1:0] rd_clr;
	logic [NUM_CNT-1:0] wr_hit;

	logic tx_ok;
	logic tx_one;
	logic tx_many;
	logic rx_end;
	logic rx_good;
	logic rx_csum_bad;
	logic [NUM_CNT-1:0] inc;

	// Counters wrap silently at 16 bits; software must read in time
	logic [CNT_W-1:0] cnt_reg [NUM_CNT];
	logic [CNT_W-1:0] cnt_next [NUM_CNT];
	logic [CNT_W-1:0] rd_value;

	logic [APB_DW-1:0] prdata_next;
	logic [APB_DW-1:0] prdata_reg;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	// ----------------------------------------------------------------
	// Bus phase
	// ----------------------------------------------------------------
	// One wait state: the first access cycle is taken, the next answers
	assign access = psel && penable && (phase_reg == PH_SETUP);

	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_IDLE:
			begin
				if (psel && !penable)
					phase_next = PH_SETUP;
			end
			PH_SETUP:
			begin
				if (access)
					phase_next = PH_ANSWER;
				else if (!psel)
					phase_next = PH_IDLE;
			end
			PH_ANSWER:
			begin
				phase_next = PH_IDLE;
			end
			default:
			begin
				phase_next = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_reg <= PH_IDLE;
		else
			phase_reg <= phase_next;
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign alias_kind = paddr[3:2];
	assign aligned = (paddr[1:0] == 2'h0);

	// Misaligned or unmapped words answer with an error, change nothing
	always_comb
	begin
		hit = 1'b1;
		sel_idx = SEL_TX_OK;
		case (paddr[7:4])
			TX_OK_OFS[7:4]:
				sel_idx = SEL_TX_OK;
			ONE_COL_OFS[7:4]:
				sel_idx = SEL_ONE_COL;
			MANY_COL_OFS[7:4]:
				sel_idx = SEL_MANY_COL;
			RX_OK_OFS[7:4]:
				sel_idx = SEL_RX_OK;
			CSUM_ERR_OFS[7:4]:
				sel_idx = SEL_CSUM_ERR;
			default:
				hit = 1'b0;
		endcase
		if (!aligned)
			hit = 1'b0;
	end

	// ----------------------------------------------------------------
	// Byte lanes
	// ----------------------------------------------------------------
	// Only lanes 0 and 1 hold counter bits; lanes 2 and 3 are ignored
	assign rd_lanes = pstrb[0] || pstrb[1];
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wr_mask = lane_mask & pwdata[CNT_MSB:0];

	// ----------------------------------------------------------------
	// Per-counter access strobes
	// ----------------------------------------------------------------
	// Reads of any alias clear, unless both low lanes are off
	genvar gd;
	generate
		for (gd = 0; gd < NUM_CNT; gd++)
		begin : g_dec
			assign mine[gd] = access && hit && (sel_idx == 3'(gd));
			assign rd_clr[gd] = mine[gd] && !pwrite && rd_lanes;
			assign wr_hit[gd] = mine[gd] && pwrite;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Transmit event qualification
	// ----------------------------------------------------------------
	// Collision flags only qualify a successful frame
	always_comb
	begin
		tx_ok = tx_evt.frame_ok;
		tx_one = tx_evt.frame_ok && tx_evt.one_collision;
		tx_many = tx_evt.frame_ok && tx_evt.many_collision;
	end

	// ----------------------------------------------------------------
	// Receive event qualification
	// ----------------------------------------------------------------
	// An alignment error is a checksum error with a dribble nibble
	always_comb
	begin
		rx_end = rx_evt.frame_done;
		rx_good = rx_end && rx_evt.filter_accept
			&& !rx_evt.checksum_error;
		rx_csum_bad = rx_end && rx_evt.checksum_error
			&& !rx_evt.dribble;
	end

	// ----------------------------------------------------------------
	// Count strobes
	// ----------------------------------------------------------------
	always_comb
	begin
		inc = '0;
		inc[IDX_TX_OK] = tx_ok;
		inc[IDX_ONE_COL] = tx_one;
		inc[IDX_MANY_COL] = tx_many;
		inc[IDX_RX_OK] = rx_good;
		inc[IDX_CSUM_ERR] = rx_csum_bad;
	end

	// ----------------------------------------------------------------
	// Counter update
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CNT; gi++)
		begin : g_cnt
			logic [CNT_W-1:0] wr_value;

			// Value a write leaves behind, before any event is added
			always_comb
			begin
				wr_value = cnt_reg[gi];
				case (alias_kind)
					ALIAS_BASE:
						wr_value = (cnt_reg[gi] & ~lane_mask) | wr_mask;
					ALIAS_CLR:
						wr_value = cnt_reg[gi] & ~wr_mask;
					ALIAS_SET:
						wr_value = cnt_reg[gi] | wr_mask;
					ALIAS_INV:
						wr_value = cnt_reg[gi] ^ wr_mask;
					default:
						wr_value = cnt_reg[gi];
				endcase
			end

			// Event added last so a coincident clear or write keeps it
			always_comb
			begin
				cnt_next[gi] = cnt_reg[gi];
				if (rd_clr[gi])
					cnt_next[gi] = CNT_RESET;
				else if (wr_hit[gi])
					cnt_next[gi] = wr_value;
				if (inc[gi])
					cnt_next[gi] = cnt_next[gi] + 16'h0001;
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cnt_reg[gi] <= CNT_RESET;
				else
					cnt_reg[gi] <= cnt_next[gi];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read select
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_value = CNT_RESET;
		case (sel_idx)
			SEL_TX_OK:
				rd_value = cnt_reg[IDX_TX_OK];
			SEL_ONE_COL:
				rd_value = cnt_reg[IDX_ONE_COL];
			SEL_MANY_COL:
				rd_value = cnt_reg[IDX_MANY_COL];
			SEL_RX_OK:
				rd_value = cnt_reg[IDX_RX_OK];
			SEL_CSUM_ERR:
				rd_value = cnt_reg[IDX_CSUM_ERR];
			default:
				rd_value = CNT_RESET;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Read data stays zero outside the answer cycle
	always_comb
	begin
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = RDATA_RESET;
		if (access)
		begin
			pready_next = 1'b1;
			if (!hit)
				pslverr_next = 1'b1;
			else if (!pwrite)
				prdata_next = {{PAD_W{1'b0}}, rd_value};
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// Each output comes straight from its own flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= pready_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= pslverr_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= RDATA_RESET;
		else
			prdata_reg <= prdata_next;
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

endmodule

/* File: tb/efsc_checker.sv */
`timescale 1ns/1ps
module efsc_checker
	import efsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("late ready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("long ready");
	a_ready_cause: assert property (pready |-> psel && $past(penable))
		else $error("stray ready");
	a_err_unmap: assert property (pready
		&& (paddr > 8'h4f || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("no error");
	a_err_mapped: assert property (pready
		&& paddr < 8'h50 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("false error");
	a_err_pulse: assert property (pslverr |-> pready)
		else $error("lone error");
	a_upper_zero: assert property (pready |-> prdata[31:16] == '0)
		else $error("upper bits");
	a_idle_quiet: assert property (!pready |-> prdata == '0)
		else $error("idle rdata");
endmodule
bind efsc_counters efsc_checker u_chk (.pclk, .presetn, .psel, .penable,
	.paddr, .prdata, .pready, .pslverr);

/* File: tb/ethernet_frame_statistics_counters_tb_top.sv */
`timescale 1ns/1ps
module ethernet_frame_statistics_counters_tb_top;
	import efsc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'h0;
	efsc_tx_evt_t tx_evt = '0;
	efsc_rx_evt_t rx_evt = '0;
	int failures = 0, cmp_count = 0;
	efsc_counters DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_evt, .rx_evt);
	initial forever #5 pclk = ~pclk;
	task finish_test;
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check_data(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("MISMATCH prdata at %h exp %h got %h", a, e, g);
			failures++;
		end
	endtask
	task check_err(input logic [7:0] a, input logic e, input logic g);
		cmp_count++;
		if (g !== e)
		begin
			$display("MISMATCH pslverr at %h exp %h got %h", a, e, g);
			failures++;
		end
	endtask
	// Reads compare; the event rides the taking edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input efsc_tx_evt_t ev);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		tx_evt <= ev;
		n = 0;
		do
		begin
			@(posedge pclk);
			tx_evt <= '0;
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			failures++;
			finish_test;
		end
		if (!w)
			check_data(a, d, prdata);
		check_err(a, a[1:0] != 2'h0 || a[7:4] > CSUM_ERR_OFS[7:4], pslverr);
		psel <= 0;
		penable <= 0;
	endtask
	task ev(input efsc_tx_evt_t t, input efsc_rx_evt_t r, input int k);
		repeat (k)
		begin
			@(posedge pclk);
			tx_evt <= t;
			rx_evt <= r;
			@(posedge pclk);
			tx_evt <= '0;
			rx_evt <= '0;
		end
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 5; i++)
			apb(0, 8'(i * 16), 0, 4'hf, '0);
		ev(3'b100, '0, 3);
		ev(3'b110, '0, 1);
		ev(3'b101, '0, 2);
		apb(0, 8'h00, 6, 4'hf, '0);
		apb(0, 8'h10, 1, 4'hf, '0);
		apb(0, 8'h20, 2, 4'hf, '0);
		apb(0, 8'h30, 0, 4'hf, '0);
		apb(0, 8'h40, 0, 4'hf, '0);
		apb(0, 8'h00, 0, 4'hf, '0);
		ev('0, 4'b1100, 2);
		ev('0, 4'b1110, 1);
		ev('0, 4'b1111, 1);
		ev('0, 4'b1000, 1);
		apb(0, 8'h30, 2, 4'hf, '0);
		apb(0, 8'h40, 1, 4'hf, '0);
		for (int i = 0; i < 3; i++)
			apb(0, 8'(i * 16), 0, 4'hf, '0);
		apb(1, 8'h08, 32'hffff_0005, 4'hf, '0);
		apb(1, 8'h0c, 32'h0000_0003, 4'hf, '0);
		apb(1, 8'h04, 32'h0000_0002, 4'hf, '0);
		apb(0, 8'h00, 4, 4'h4, '0);
		apb(0, 8'h00, 4, 4'h1, '0);
		apb(0, 8'h00, 0, 4'hf, '0);
		apb(1, 8'h00, 32'h0000_1234, 4'h1, '0);
		apb(0, 8'h00, 32'h34, 4'hf, 3'b100);
		apb(0, 8'h00, 1, 4'hf, '0);
		apb(0, 8'h50, 0, 4'hf, '0);
		apb(0, 8'h02, 0, 4'hf, '0);
		finish_test;
	end
endmodule
